// >>> hdl/timer_irq_pkg.sv
// Register map, field positions and timing counts of the timer flag block.
// Assumes a 16-bit AXI4-Lite byte address; each register sits at four times its index.
package timer_irq_pkg;
  // Bus widths
  localparam int ADDR_W = 16;
  localparam int IDX_W = 14;
  // Register indexes (byte address is index * 4)
  localparam logic [IDX_W-1:0] IDX_EDGE_CTRL = 14'h1021;
  localparam logic [IDX_W-1:0] IDX_MASK_A = 14'h1022;
  localparam logic [IDX_W-1:0] IDX_FLAG_A = 14'h1023;
  localparam logic [IDX_W-1:0] IDX_MASK_B = 14'h1024;
  localparam logic [IDX_W-1:0] IDX_FLAG_B = 14'h1025;
  localparam logic [IDX_W-1:0] IDX_PULSE_CTRL = 14'h1026;
  localparam logic [IDX_W-1:0] IDX_COUNT = 14'h1027;
  // Reset value of every control and flag register
  localparam logic [7:0] REG_RESET = 8'h00;
  // Second flag and mask register fields
  localparam int FB_OVERFLOW = 7;
  localparam int FB_PERIODIC = 6;
  localparam int FB_PULSE_WRAP = 5;
  localparam int FB_PULSE_EDGE = 4;
  // Pulse accumulator control fields
  localparam int PC_PORT_DIR = 7;
  localparam int PC_ENABLE = 6;
  localparam int PC_MODE = 5;
  localparam int PC_EDGE = 4;
  // Prescaler write window in E cycles
  localparam logic [6:0] PRESCALE_WINDOW = 7'h40;
  // Gated accumulation tick, E divided by 64
  localparam logic [5:0] GATE_DIV_LAST = 6'h3F;
  // Shortest periodic divide is 2**13
  localparam int RATE_BASE = 13;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : timer_irq_pkg

// >>> hdl/timer_irq_prescale_rti.sv
// Free-running timer flags, masks, prescaler, periodic tick and pulse counter.
// Assumes one clock, pins already synchronous, and an AXI4-Lite master.
`timescale 1ns/1ps

module timer_irq_prescale_rti (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic special_mode,
  input wire logic [4:0][15:0] compare_value,
  input wire logic [2:0] capture_pins,
  input wire logic pulse_input_pin,
  output logic irq,
  output logic [15:0] free_running_count,
  input wire logic [timer_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [timer_irq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Last prescaler phase for each divide select
  function automatic logic [3:0] prescale_last(input logic [1:0] sel);
    unique case (sel)
      2'h0: prescale_last = 4'h0;
      2'h1: prescale_last = 4'h3;
      2'h2: prescale_last = 4'h7;
      2'h3: prescale_last = 4'hF;
    endcase
  endfunction : prescale_last

  // Whether an edge pair meets a capture edge code
  function automatic logic capture_hit(input logic [1:0] sel, input logic rise,
                                       input logic fall);
    unique case (sel)
      2'h0: capture_hit = 1'b0;
      2'h1: capture_hit = rise;
      2'h2: capture_hit = fall;
      2'h3: capture_hit = rise | fall;
    endcase
  endfunction : capture_hit

  // Register index carried by a byte address
  function automatic logic [timer_irq_pkg::IDX_W-1:0] reg_index(
    input logic [timer_irq_pkg::ADDR_W-1:0] addr);
    reg_index = addr[timer_irq_pkg::ADDR_W-1:2];
  endfunction : reg_index

  logic [7:0] mask_a_ff; // Compare and capture enables
  logic [7:0] flag_a_ff; // Compare and capture flags
  logic [3:0] mask_b_ff; // Upper enables of second mask
  logic [3:0] flag_b_ff; // Overflow, periodic, wrap, edge flags
  logic [1:0] prescale_sel_ff; // Count divide select
  logic [7:0] pulse_ctrl_ff; // Pulse control, bits 3..2 kept zero
  logic [5:0] edge_ctrl_ff; // Three two-bit capture edge codes
  logic [15:0] count_ff; // Free-running count
  logic [3:0] prescale_ff; // Phase within the divide
  logic [15:0] rate_div_ff; // E cycle divider for periodic tick
  logic [7:0] pulse_count_ff; // Pulse accumulator count
  logic [5:0] gate_div_ff; // E over 64 for gated mode
  logic [6:0] window_ff; // Cycles since reset, saturating
  logic prescale_done_ff; // Prescaler already written once
  logic [2:0] cap_prev_ff; // Last capture pin levels
  logic pulse_prev_ff; // Last pulse pin level
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;

  // Write channel handshake: address and data taken together
  logic wr_take;
  logic wr_lane;
  logic [timer_irq_pkg::IDX_W-1:0] wr_idx;
  logic [7:0] wr_byte;
  logic rd_take;
  logic wr_mapped;
  assign wr_take = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
  assign wr_lane = wr_take & s_axi_wstrb[0];
  assign wr_idx = reg_index(s_axi_awaddr);
  assign wr_byte = s_axi_wdata[7:0];
  assign rd_take = s_axi_arvalid & ~rvalid_ff;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = rd_take;
  assign wr_mapped = wr_idx inside {timer_irq_pkg::IDX_EDGE_CTRL, timer_irq_pkg::IDX_MASK_A,
    timer_irq_pkg::IDX_FLAG_A, timer_irq_pkg::IDX_MASK_B, timer_irq_pkg::IDX_FLAG_B,
    timer_irq_pkg::IDX_PULSE_CTRL, timer_irq_pkg::IDX_COUNT};

  // Per-register write strobes
  logic wr_mask_a, wr_flag_a, wr_mask_b, wr_flag_b, wr_pulse, wr_edge;
  assign wr_mask_a = wr_lane & (wr_idx == timer_irq_pkg::IDX_MASK_A);
  assign wr_flag_a = wr_lane & (wr_idx == timer_irq_pkg::IDX_FLAG_A);
  assign wr_mask_b = wr_lane & (wr_idx == timer_irq_pkg::IDX_MASK_B);
  assign wr_flag_b = wr_lane & (wr_idx == timer_irq_pkg::IDX_FLAG_B);
  assign wr_pulse = wr_lane & (wr_idx == timer_irq_pkg::IDX_PULSE_CTRL);
  assign wr_edge = wr_lane & (wr_idx == timer_irq_pkg::IDX_EDGE_CTRL);

  // Write response, one cycle after the take
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= timer_irq_pkg::RESP_OKAY;
    end else if (wr_take) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_mapped ? timer_irq_pkg::RESP_OKAY : timer_irq_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // Read mux; unmapped words read zero with an error
  logic [7:0] nxt_rbyte;
  logic nxt_rerr;
  always_comb begin
    nxt_rbyte = 8'h00;
    nxt_rerr = 1'b0;
    unique case (reg_index(s_axi_araddr))
      timer_irq_pkg::IDX_EDGE_CTRL: nxt_rbyte = {2'h0, edge_ctrl_ff};
      timer_irq_pkg::IDX_MASK_A: nxt_rbyte = mask_a_ff;
      timer_irq_pkg::IDX_FLAG_A: nxt_rbyte = flag_a_ff;
      timer_irq_pkg::IDX_MASK_B: nxt_rbyte = {mask_b_ff, 2'h0, prescale_sel_ff};
      timer_irq_pkg::IDX_FLAG_B: nxt_rbyte = {flag_b_ff, 4'h0};
      timer_irq_pkg::IDX_PULSE_CTRL: nxt_rbyte = pulse_ctrl_ff;
      timer_irq_pkg::IDX_COUNT: nxt_rbyte = pulse_count_ff;
      default: nxt_rerr = 1'b1;
    endcase
  end

  // Read response, one cycle after the take
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= timer_irq_pkg::RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= nxt_rerr ? timer_irq_pkg::RESP_SLVERR : timer_irq_pkg::RESP_OKAY;
      rdata_ff <= {24'h00_0000, nxt_rbyte};
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // Plain control registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask_a_ff <= timer_irq_pkg::REG_RESET;
      mask_b_ff <= 4'h0;
      pulse_ctrl_ff <= timer_irq_pkg::REG_RESET;
      edge_ctrl_ff <= 6'h00;
    end else begin
      if (wr_mask_a) mask_a_ff <= wr_byte;
      if (wr_mask_b) mask_b_ff <= wr_byte[7:4];
      if (wr_pulse) pulse_ctrl_ff <= {wr_byte[7:4], 2'h0, wr_byte[1:0]};
      if (wr_edge) edge_ctrl_ff <= wr_byte[5:0];
    end
  end

  // Write-once prescaler; special mode lifts the lock for test
  logic prescale_open;
  assign prescale_open = special_mode |
    (~prescale_done_ff & (window_ff < timer_irq_pkg::PRESCALE_WINDOW));
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prescale_sel_ff <= 2'h0;
      prescale_done_ff <= 1'b0;
      window_ff <= 7'h00;
    end else begin
      if (window_ff < timer_irq_pkg::PRESCALE_WINDOW) window_ff <= window_ff + 7'h01;
      if (wr_mask_b && prescale_open) begin
        prescale_sel_ff <= wr_byte[1:0];
        prescale_done_ff <= 1'b1;
      end
    end
  end

  // Prescaled free-running count
  logic count_tick;
  logic [15:0] nxt_count;
  assign count_tick = (prescale_ff == prescale_last(prescale_sel_ff));
  assign nxt_count = count_ff + 16'h0001;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prescale_ff <= 4'h0;
      count_ff <= 16'h0000;
    end else begin
      // advance every 1, 4, 8, 16
      prescale_ff <= count_tick ? 4'h0 : prescale_ff + 4'h1;
      if (count_tick) count_ff <= nxt_count;
    end
  end
  assign free_running_count = count_ff;

  // Periodic tick: all low 13+rate divider bits at one
  logic [15:0] rate_mask;
  logic periodic_tick;
  assign rate_mask = 16'hFFFF >> (2'h3 - pulse_ctrl_ff[1:0]);
  assign periodic_tick = ((rate_div_ff & rate_mask) == rate_mask);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) rate_div_ff <= 16'h0000;
    else rate_div_ff <= rate_div_ff + 16'h0001;
  end

  // Edge detection on capture and pulse pins
  logic [2:0] cap_rise, cap_fall, cap_event;
  logic pulse_active_edge, pulse_inc;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cap_prev_ff <= 3'h0;
      pulse_prev_ff <= 1'b0;
    end else begin
      cap_prev_ff <= capture_pins;
      pulse_prev_ff <= pulse_input_pin;
    end
  end
  assign cap_rise = capture_pins & ~cap_prev_ff;
  assign cap_fall = ~capture_pins & cap_prev_ff;
  // edge code per channel, channel 1 in top pair
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cap_event[2-i] = capture_hit(edge_ctrl_ff[5-2*i -: 2], cap_rise[2-i], cap_fall[2-i]);
    end
  end
  // Edge select 1 picks rising edges, 0 falling
  assign pulse_active_edge = pulse_ctrl_ff[timer_irq_pkg::PC_ENABLE] &
    (pulse_ctrl_ff[timer_irq_pkg::PC_EDGE] ? (pulse_input_pin & ~pulse_prev_ff)
                                           : (~pulse_input_pin & pulse_prev_ff));
  // Event mode counts edges; gated mode counts E/64 while pin is not inhibiting
  assign pulse_inc = pulse_ctrl_ff[timer_irq_pkg::PC_MODE] ?
    (pulse_ctrl_ff[timer_irq_pkg::PC_ENABLE] & (gate_div_ff == timer_irq_pkg::GATE_DIV_LAST) &
     (pulse_input_pin != pulse_ctrl_ff[timer_irq_pkg::PC_EDGE])) : pulse_active_edge;

  // Pulse count; software may overwrite it, and the write wins over a count
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulse_count_ff <= 8'h00;
      gate_div_ff <= 6'h00;
    end else begin
      gate_div_ff <= gate_div_ff + 6'h01;
      if (wr_lane && wr_idx == timer_irq_pkg::IDX_COUNT) pulse_count_ff <= wr_byte;
      else if (pulse_inc) pulse_count_ff <= pulse_count_ff + 8'h01;
    end
  end

  // Event sets for both flag registers
  logic [7:0] set_a;
  logic [3:0] set_b;
  always_comb begin
    // compare matches on the new count
    for (int i = 0; i < 5; i++) begin
      set_a[7-i] = count_tick & (nxt_count == compare_value[i]);
    end
    set_a[2:0] = cap_event;
    set_b[3] = count_tick & (count_ff == 16'hFFFF);
    set_b[2] = periodic_tick;
    set_b[1] = pulse_inc & (pulse_count_ff == 8'hFF) &
      ~(wr_lane && wr_idx == timer_irq_pkg::IDX_COUNT);
    set_b[0] = pulse_active_edge;
  end

  // Sticky flags; a set in the clearing cycle survives
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_a_ff <= timer_irq_pkg::REG_RESET;
      flag_b_ff <= 4'h0;
    end else begin
      flag_a_ff <= (flag_a_ff & ~(wr_flag_a ? wr_byte : 8'h00)) | set_a;
      flag_b_ff <= (flag_b_ff & ~(wr_flag_b ? wr_byte[7:4] : 4'h0)) | set_b;
    end
  end

  // masked flags raise the level interrupt
  assign irq = |(flag_a_ff & mask_a_ff) | |(flag_b_ff & mask_b_ff);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_write_taken;
    wr_take;
  endsequence
  sequence s_resp_held;
    s_axi_bvalid[*1];
  endsequence
  chk_write_response: assert property (s_write_taken |=> s_resp_held)
    else $error("write not answered next cycle");
  chk_irq_level: assert property ((|(set_b & mask_b_ff)) && !wr_mask_b |=> irq)
    else $error("unmasked flag did not raise interrupt");
  chk_overflow_set: assert property (count_tick && count_ff == 16'hFFFF
    |=> count_ff == 16'h0000 && flag_b_ff[3])
    else $error("overflow flag missed on rollover");
  chk_flag_clear: assert property (wr_flag_a && wr_byte[7] && !set_a[7] |=> !flag_a_ff[7])
    else $error("flag not cleared by writing one");
  chk_prescale_lock: assert property (wr_mask_b && window_ff == 7'h40 && !special_mode
    |=> prescale_sel_ff == $past(prescale_sel_ff))
    else $error("prescaler changed after its window");
  chk_periodic_base: assert property (pulse_ctrl_ff[1:0] == 2'h0 &&
    rate_div_ff[12:0] == 13'h1FFF |=> flag_b_ff[2])
    else $error("periodic flag missed at base rate");
  // Test modes may change the divide mid-interval, so the check rests there
  chk_prescale_rate: assert property (disable iff (rst || special_mode)
    prescale_sel_ff == 2'h1 && count_tick |=> !count_tick [*3] ##1 count_tick)
    else $error("divide by four not kept");
  chk_pulse_wrap: assert property (pulse_inc && pulse_count_ff == 8'hFF && !wr_lane
    |=> pulse_count_ff == 8'h00 && flag_b_ff[1])
    else $error("pulse wrap flag missed");
  chk_capture_rise: assert property (edge_ctrl_ff[5:4] == 2'h1 && cap_fall[2] && !wr_flag_a
    && !flag_a_ff[2] |=> !flag_a_ff[2])
    else $error("falling edge captured in rising mode");

endmodule : timer_irq_prescale_rti

// >>> tb/tb_timer_irq_prescale_rti.sv
// Self-checking bench for the timer flag block: AXI4-Lite register tasks and directed tests.
// Assumes the design carries its own assertions; one 200 MHz clock, no partner model.
`timescale 1ns/1ps
module tb_timer_irq_prescale_rti;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic special_mode = 1'b0;
  logic [4:0][15:0] compare_value = {5{16'hFFFF}};
  logic [2:0] capture_pins = 3'h0;
  logic pulse_input_pin = 1'b0;
  logic irq;
  logic [15:0] free_running_count;
  logic [15:0] s_axi_awaddr = 16'h0000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [15:0] s_axi_araddr = 16'h0000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  int n_mismatch = 0; // Failed comparisons and timeouts
  int checks_done = 0; // Comparisons made
  int cyc = 0; // Free cycle stamp for interval checks

  timer_irq_prescale_rti u_dut (
    .clk_sys(clk_sys), .rst(rst), .special_mode(special_mode), .compare_value(compare_value),
    .capture_pins(capture_pins), .pulse_input_pin(pulse_input_pin), .irq(irq),
    .free_running_count(free_running_count), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );

  // 200 MHz clock and cycle stamp
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  // Verdict, printed once
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  // A bound ran out: count it and stop
  task automatic stall(input string what);
    n_mismatch++;
    $display("MISMATCH %s expected handshake seen timeout", what);
    wrap_up();
  endtask : stall

  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_reg

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_resp

  // Cycle counts are bench values, so plain int is safe here
  task automatic chk_cyc(input string what, input int exp, input int got);
    checks_done++;
    if (got != exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_cyc

  // Write one byte; address and data may be taken on different edges
  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    logic aw_ok, w_ok, aw_done, w_done;
    int n;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      // Ready is settled mid-cycle and holds to the next edge
      @(negedge clk_sys);
      aw_ok = s_axi_awready && !aw_done;
      w_ok = s_axi_wready && !w_done;
      @(posedge clk_sys);
      if (aw_ok) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_ok) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
      n++;
      if (n > 200) stall("write address and data");
    end
    n = 0;
    while (1) begin
      @(negedge clk_sys);
      if (s_axi_bvalid === 1'b1) break;
      n++;
      if (n > 200) stall("write response");
    end
    chk_resp("write response", timer_irq_pkg::RESP_OKAY, s_axi_bresp);
    @(posedge clk_sys);
    s_axi_bready <= 1'b0;
  endtask : wr

  // Read one word; low byte and response returned
  task automatic rd(input logic [13:0] idx, output logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (1) begin
      @(negedge clk_sys);
      if (s_axi_arready === 1'b1) break;
      n++;
      if (n > 200) stall("read address");
    end
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    while (1) begin
      @(negedge clk_sys);
      if (s_axi_rvalid === 1'b1) break;
      n++;
      if (n > 400) stall("read data");
    end
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    chk_reg("upper read bits", 8'h00, s_axi_rdata[31:24] | s_axi_rdata[23:16] | s_axi_rdata[15:8]);
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rd_chk(input logic [13:0] idx, input logic [7:0] m, input logic [7:0] exp,
                        input string what);
    logic [7:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk_resp(what, timer_irq_pkg::RESP_OKAY, r);
    chk_reg(what, exp, d & m);
  endtask : rd_chk

  task automatic irq_chk(input logic exp, input string what);
    @(negedge clk_sys);
    chk_reg(what, {7'h00, exp}, {7'h00, irq});
  endtask : irq_chk

  task automatic wait_irq(input int lim, output int stamp);
    int n;
    for (n = 0; n < lim; n++) begin
      @(negedge clk_sys);
      if (irq === 1'b1) break;
    end
    if (n >= lim) stall("interrupt");
    stamp = cyc;
  endtask : wait_irq

  // Cycles between two successive count steps
  task automatic step_gap(output int g);
    logic [15:0] c0;
    int t1, k, n;
    @(negedge clk_sys);
    for (k = 0; k < 2; k++) begin
      c0 = free_running_count;
      for (n = 0; n < 100 && free_running_count === c0; n++) @(negedge clk_sys);
      if (n >= 100) stall("count step");
      if (k == 0) t1 = cyc;
    end
    g = cyc - t1;
  endtask : step_gap

  // Interval between two periodic flags, cleared after each
  task automatic period(input int exp, input string what);
    int t1, t2;
    wait_irq(70000, t1);
    wr(timer_irq_pkg::IDX_FLAG_B, 8'h40);
    wait_irq(70000, t2);
    wr(timer_irq_pkg::IDX_FLAG_B, 8'h40);
    chk_cyc(what, exp, t2 - t1);
  endtask : period

  initial begin
    logic [7:0] d;
    logic [1:0] r;
    int g, t;
    int pre[4] = '{1, 4, 8, 16};
    logic [13:0] regs[5] = '{timer_irq_pkg::IDX_MASK_A, timer_irq_pkg::IDX_FLAG_A,
      timer_irq_pkg::IDX_MASK_B, timer_irq_pkg::IDX_FLAG_B, timer_irq_pkg::IDX_PULSE_CTRL};
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values, and an unmapped place
    for (int i = 0; i < 5; i++) rd_chk(regs[i], 8'hFF, timer_irq_pkg::REG_RESET, "reset value");
    rd(14'h0000, d, r);
    chk_resp("unmapped read", timer_irq_pkg::RESP_SLVERR, r);
    chk_reg("unmapped data", 8'h00, d);
    // Prescaler inside the window, then a late write that must be dropped
    wr(timer_irq_pkg::IDX_MASK_B, 8'h01);
    step_gap(g);
    chk_cyc("divide by 4 step", 4, g);
    repeat (80) @(posedge clk_sys);
    wr(timer_irq_pkg::IDX_MASK_B, 8'h02);
    rd_chk(timer_irq_pkg::IDX_MASK_B, 8'h03, 8'h01, "late prescale");
    // Test mode unlocks the prescaler; every code, ending on divide by 1
    special_mode <= 1'b1;
    for (int i = 3; i >= 0; i--) begin
      wr(timer_irq_pkg::IDX_MASK_B, 8'(i));
      step_gap(g);
      chk_cyc("prescale step", pre[i], g);
    end
    wr(timer_irq_pkg::IDX_PULSE_CTRL, 8'hFF);
    rd_chk(timer_irq_pkg::IDX_PULSE_CTRL, 8'hFF, 8'hF3, "pulse ctrl layout");
    // Capture on the first channel for each edge code
    for (int i = 0; i < 4; i++) begin
      wr(timer_irq_pkg::IDX_EDGE_CTRL, {2'b00, 2'(i), 4'h0});
      wr(timer_irq_pkg::IDX_FLAG_A, 8'hFF);
      @(posedge clk_sys);
      capture_pins <= 3'h4;
      repeat (3) @(posedge clk_sys);
      rd_chk(timer_irq_pkg::IDX_FLAG_A, 8'h07, {5'h00, 1'(i), 2'h0}, "rising capture");
      wr(timer_irq_pkg::IDX_FLAG_A, 8'hFF);
      capture_pins <= 3'h0;
      repeat (3) @(posedge clk_sys);
      rd_chk(timer_irq_pkg::IDX_FLAG_A, 8'h07, {5'h00, 1'(i >> 1), 2'h0}, "falling capture");
      wr(timer_irq_pkg::IDX_FLAG_A, 8'hFF);
    end
    // First compare, its mask, and selective clearing
    // Count sampled mid-cycle, away from the edge that moves it
    @(negedge clk_sys);
    g = int'(free_running_count);
    @(posedge clk_sys);
    compare_value[0] <= 16'(g + 32'h0000_0040);
    repeat (100) @(posedge clk_sys);
    rd_chk(timer_irq_pkg::IDX_FLAG_A, 8'h80, 8'h80, "compare flag");
    wr(timer_irq_pkg::IDX_MASK_A, 8'h80);
    irq_chk(1'b1, "compare irq");
    wr(timer_irq_pkg::IDX_MASK_A, 8'h7F);
    irq_chk(1'b0, "compare masked");
    wr(timer_irq_pkg::IDX_FLAG_A, 8'h80);
    rd_chk(timer_irq_pkg::IDX_FLAG_A, 8'hFF, 8'h00, "compare cleared");
    wr(timer_irq_pkg::IDX_MASK_A, 8'h00);
    // Pulse counter wraps from FE on the second rising edge
    wr(timer_irq_pkg::IDX_PULSE_CTRL, 8'h50);
    wr(timer_irq_pkg::IDX_COUNT, 8'hFE);
    wr(timer_irq_pkg::IDX_FLAG_B, 8'h30);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      pulse_input_pin <= 1'b1;
      repeat (2) @(posedge clk_sys);
      pulse_input_pin <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    rd_chk(timer_irq_pkg::IDX_FLAG_B, 8'h30, 8'h30, "pulse wrap and edge");
    rd_chk(timer_irq_pkg::IDX_COUNT, 8'hFF, 8'h00, "pulse count");
    // Periodic rates through the second mask
    wr(timer_irq_pkg::IDX_MASK_B, 8'h40);
    wr(timer_irq_pkg::IDX_FLAG_B, 8'h40);
    period(8192, "rate 0 interval");
    wr(timer_irq_pkg::IDX_PULSE_CTRL, 8'h51);
    period(16384, "rate 1 interval");
    // Overflow while the pulse flags stay set
    wr(timer_irq_pkg::IDX_MASK_B, 8'h80);
    wait_irq(70000, t);
    rd_chk(timer_irq_pkg::IDX_FLAG_B, 8'h8F, 8'h80, "overflow flag");
    wr(timer_irq_pkg::IDX_FLAG_B, 8'h80);
    rd_chk(timer_irq_pkg::IDX_FLAG_B, 8'hBF, 8'h30, "overflow cleared");
    irq_chk(1'b0, "overflow irq low");
    wrap_up();
  end
endmodule : tb_timer_irq_prescale_rti
